// *** rtl/jtag_prog_consts.vh ***
`ifndef JTAG_PROG_CONSTS_VH
`define JTAG_PROG_CONSTS_VH
`define IR_HOLD_RESET 4'hC
`define IR_UNLOCK 4'h4
`define IR_COMMAND 4'h5
`define IR_PAGE_LOAD 4'h6
`define IR_PAGE_READ 4'h7
`define IR_BYPASS 4'hF
`define UNLOCK_KEY 16'hA370
`define UNLOCK_RESET 16'h0000
`define CMD_WIDTH 15
`define BYTE_WIDTH 8
`define DISABLE_CLEAR_CYCLES 2'h2
`define PAGE_WRITE_TCK 4'hB
`define ADDR_WIDTH 13
`define RESET_TIMEOUT_CYCLES 16'h0040
`endif

// *** rtl/byte_fifo.v ***
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Write side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Read side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_r;
  reg [AW:0] rd_r;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  always @*
    out_data = mem[rd_r[AW-1:0]];
  always @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wr_r[AW-1:0]] <= in_data;
    if (srst)
    begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wr_r <= wr_r + 1'b1;
      if (out_ready && !empty)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule // byte_fifo

// *** rtl/jtag_prog_port.v ***
`timescale 1ns/10ps
`include "jtag_prog_consts.vh"
// Function
// - Port works only with enable fuse programmed and disable bit clear.
// - External reset low clears a set disable bit after two chip clocks.
// - All shift registers move least significant bit first.
// - Four-bit instruction register selects the data register path.
// - Run-Test/Idle generates internal clocks and serves as idle state.
// - Code 0xC selects one-bit reset chain; controller is not reset.
// - A one in the reset chain holds the chip in reset immediately.
// - After chain release reset lasts for the fuse-chosen time-out.
// - Code 0x4 selects 16-bit unlock register, compared on Update-DR.
// - Programming enabled only when unlock register equals the key.
// - Unlock register clears on reset; host clears it on leaving.
// - Code 0x5 selects 15-bit command register; capture loads result.
// - Update-DR applies command; following idle yields one execute clock.
// - Code 0x6 selects 8-bit byte register, low bits of command register.
// - Page-load update copies byte, writes page buffer within eleven clocks; byte queued in 32-entry FIFO until page_wr_ready, dropped if full.
// - Page-load alternates low/high, pre-increment address except first.
// - Code 0x7 captures flash bytes alternating, post-increment after high.
module jtag_prog_port (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  // Chip control
  input wire test_port_enable_fuse,
  input wire ext_reset_n,
  input wire disable_set,
  output reg test_port_disable_bit,
  output wire chip_reset,
  input wire [15:0] reset_timeout_cycles,
  // Memory programming interface
  output reg [`CMD_WIDTH-1:0] mem_cmd,
  output reg mem_cmd_strobe,
  output reg mem_exec_clk,
  input wire [`CMD_WIDTH-1:0] mem_result,
  output reg [`ADDR_WIDTH-1:0] page_addr,
  output wire page_wr_valid,
  input wire page_wr_ready,
  output wire [`ADDR_WIDTH-1:0] page_wr_addr,
  output wire page_wr_high,
  output wire [`BYTE_WIDTH-1:0] page_wr_byte,
  input wire [15:0] flash_word,
  output reg prog_mode
);
  // Test controller states, binary coded.
  localparam [3:0] TAP_RESET = 4'h0;
  localparam [3:0] TAP_IDLE = 4'h1;
  localparam [3:0] TAP_SEL_DR = 4'h2;
  localparam [3:0] TAP_CAP_DR = 4'h3;
  localparam [3:0] TAP_SHIFT_DR = 4'h4;
  localparam [3:0] TAP_EXIT1_DR = 4'h5;
  localparam [3:0] TAP_PAUSE_DR = 4'h6;
  localparam [3:0] TAP_EXIT2_DR = 4'h7;
  localparam [3:0] TAP_UPD_DR = 4'h8;
  localparam [3:0] TAP_SEL_IR = 4'h9;
  localparam [3:0] TAP_CAP_IR = 4'hA;
  localparam [3:0] TAP_SHIFT_IR = 4'hB;
  localparam [3:0] TAP_EXIT1_IR = 4'hC;
  localparam [3:0] TAP_PAUSE_IR = 4'hD;
  localparam [3:0] TAP_EXIT2_IR = 4'hE;
  localparam [3:0] TAP_UPD_IR = 4'hF;
  reg [2:0] tck_s;
  reg [1:0] tms_s;
  reg [1:0] tdi_s;
  reg [1:0] rstn_s;
  reg [3:0] tap_r;
  reg [3:0] tap_nxt;
  reg [3:0] ir_r;
  reg [3:0] ir_shift_r;
  reg reset_chain;
  reg [15:0] program_unlock_key;
  reg [`CMD_WIDTH-1:0] program_command_shift;
  reg bypass_r;
  reg load_high_r;
  reg load_first_r;
  reg read_high_r;
  reg idle_pend_r;
  reg [1:0] dis_cnt_r;
  reg [15:0] rst_to_r;
  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire tck_fall = ~tck_s[1] & tck_s[2];
  wire tms_i = tms_s[1];
  wire tdi_i = tdi_s[1];
  wire port_on = test_port_enable_fuse & ~test_port_disable_bit;
  wire [`BYTE_WIDTH-1:0] page_byte_shift = program_command_shift[`BYTE_WIDTH-1:0];
  wire fifo_in_ready;
  wire upd_dr = tck_rise && tap_r == TAP_UPD_DR;
  wire cap_dr = tck_rise && tap_r == TAP_CAP_DR;
  wire sh_dr = tck_rise && tap_r == TAP_SHIFT_DR;
  assign chip_reset = reset_chain | (rst_to_r != 16'h0000) | ~rstn_s[1];

  always @(posedge clk)
  begin
    if (srst)
    begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      rstn_s <= 2'h3;
    end
    else
    begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      rstn_s <= {rstn_s[0], ext_reset_n};
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      test_port_disable_bit <= 1'b0;
      dis_cnt_r <= 2'h0;
    end
    else if (disable_set)
    begin
      test_port_disable_bit <= 1'b1;
      dis_cnt_r <= 2'h0;
    end
    else if (test_port_disable_bit && !rstn_s[1])
    begin
      if (dis_cnt_r == `DISABLE_CLEAR_CYCLES - 2'h1)
        test_port_disable_bit <= 1'b0;
      dis_cnt_r <= dis_cnt_r + 2'h1;
    end
    else
      dis_cnt_r <= 2'h0;
  end

  always @*
  begin
    case (tap_r)
      TAP_RESET: tap_nxt = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_nxt = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_nxt = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_nxt = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_nxt = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_nxt = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_nxt = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_nxt = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_nxt = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_nxt = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_nxt = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_nxt = tms_i ? TAP_SEL_DR : TAP_IDLE;
      default: tap_nxt = TAP_RESET;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst || !port_on)
    begin
      tap_r <= TAP_RESET;
      ir_r <= `IR_BYPASS;
      ir_shift_r <= 4'h0;
      bypass_r <= 1'b0;
      reset_chain <= 1'b0;
      program_unlock_key <= `UNLOCK_RESET;
      program_command_shift <= {`CMD_WIDTH{1'b0}};
      prog_mode <= 1'b0;
      mem_cmd <= {`CMD_WIDTH{1'b0}};
      mem_cmd_strobe <= 1'b0;
      mem_exec_clk <= 1'b0;
      idle_pend_r <= 1'b0;
      page_addr <= {`ADDR_WIDTH{1'b0}};
      load_high_r <= 1'b0;
      load_first_r <= 1'b1;
      read_high_r <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      rst_to_r <= 16'h0000;
    end
    else
    begin
      mem_cmd_strobe <= 1'b0;
      mem_exec_clk <= 1'b0;
      if (reset_chain)
        rst_to_r <= reset_timeout_cycles;
      else if (rst_to_r != 16'h0000)
        rst_to_r <= rst_to_r - 16'h0001;
      if (tck_rise)
        tap_r <= tap_nxt;
      if (tck_rise && tap_r == TAP_CAP_IR)
        ir_shift_r <= 4'h1;
      if (tck_rise && tap_r == TAP_SHIFT_IR)
        ir_shift_r <= {tdi_i, ir_shift_r[3:1]};
      if (tck_rise && tap_r == TAP_UPD_IR)
      begin
        ir_r <= ir_shift_r;
        load_high_r <= 1'b0;
        load_first_r <= 1'b1;
        read_high_r <= 1'b0;
      end
      if (tck_rise && tap_r == TAP_RESET)
        ir_r <= `IR_BYPASS;
      if (sh_dr)
        bypass_r <= tdi_i;
      if (sh_dr && ir_r == `IR_HOLD_RESET)
        reset_chain <= tdi_i;
      if (sh_dr && ir_r == `IR_UNLOCK)
        program_unlock_key <= {tdi_i, program_unlock_key[15:1]};
      if (upd_dr && ir_r == `IR_UNLOCK)
        prog_mode <= (program_unlock_key == `UNLOCK_KEY);
      if (cap_dr && ir_r == `IR_COMMAND)
        program_command_shift <= mem_result;
      if (sh_dr && ir_r == `IR_COMMAND)
        program_command_shift <= {tdi_i, program_command_shift[`CMD_WIDTH-1:1]};
      if (sh_dr && (ir_r == `IR_PAGE_LOAD || ir_r == `IR_PAGE_READ))
        program_command_shift[`BYTE_WIDTH-1:0] <= {tdi_i, page_byte_shift[7:1]};
      if (upd_dr && ir_r == `IR_COMMAND && prog_mode)
      begin
        mem_cmd <= program_command_shift;
        mem_cmd_strobe <= 1'b1;
        idle_pend_r <= 1'b1;
      end
      if (tck_rise && tap_r == TAP_IDLE && idle_pend_r)
      begin
        mem_exec_clk <= 1'b1;
        idle_pend_r <= 1'b0;
      end
      if (upd_dr && ir_r == `IR_PAGE_LOAD && prog_mode && fifo_in_ready)
      begin
        if (!load_high_r && !load_first_r)
          page_addr <= page_addr + 1'b1;
        load_high_r <= ~load_high_r;
        load_first_r <= 1'b0;
      end
      if (cap_dr && ir_r == `IR_PAGE_READ && prog_mode)
      begin
        program_command_shift[`BYTE_WIDTH-1:0] <= read_high_r ? flash_word[15:8] :
          flash_word[7:0];
        if (read_high_r)
          page_addr <= page_addr + 1'b1;
        read_high_r <= ~read_high_r;
      end
      if (tck_fall)
      begin
        tdo_oe <= (tap_r == TAP_SHIFT_DR) || (tap_r == TAP_SHIFT_IR);
        if (tap_r == TAP_SHIFT_IR)
          tdo <= ir_shift_r[0];
        else
          case (ir_r)
            `IR_HOLD_RESET: tdo <= reset_chain;
            `IR_UNLOCK: tdo <= program_unlock_key[0];
            `IR_COMMAND, `IR_PAGE_LOAD, `IR_PAGE_READ: tdo <= program_command_shift[0];
            default: tdo <= bypass_r;
          endcase
      end
    end
  end

  wire page_push = upd_dr && ir_r == `IR_PAGE_LOAD && prog_mode && port_on && !srst;
  wire [`ADDR_WIDTH-1:0] push_addr = (!load_high_r && !load_first_r) ?
    page_addr + 1'b1 : page_addr;
  byte_fifo #(
    .WIDTH(`ADDR_WIDTH + 1 + `BYTE_WIDTH),
    .DEPTH(32),
    .AW(5)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(page_push),
    .in_ready(fifo_in_ready),
    .in_data({push_addr, load_high_r, page_byte_shift}),
    .out_valid(page_wr_valid),
    .out_ready(page_wr_ready),
    .out_data({page_wr_addr, page_wr_high, page_wr_byte})
  );
endmodule // jtag_prog_port

// *** bench/jtag_prog_sva.sv ***
`timescale 1ns/10ps
module jtag_prog_sva (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Watched ports
  input wire tdo_oe,
  input wire test_port_enable_fuse,
  input wire ext_reset_n,
  input wire disable_set,
  input wire test_port_disable_bit,
  input wire chip_reset,
  input wire mem_cmd_strobe,
  input wire mem_exec_clk,
  input wire prog_mode,
  input wire page_wr_valid,
  input wire page_wr_ready,
  input wire [12:0] page_wr_addr,
  input wire page_wr_high,
  input wire [7:0] page_wr_byte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_cmd_locked: assert property (mem_cmd_strobe |-> prog_mode)
    else $error("Command strobe while locked.");
  a_strobe_single: assert property (mem_cmd_strobe |=> !mem_cmd_strobe)
    else $error("Command strobe too long.");
  a_exec_single: assert property (mem_exec_clk |=> !mem_exec_clk)
    else $error("Execute clock too long.");
  a_disable_clear: assert property (
      (!ext_reset_n && !disable_set) [*6] |-> !test_port_disable_bit)
    else $error("Disable bit not cleared.");
  a_port_off: assert property ((!test_port_enable_fuse) [*3] |-> !tdo_oe)
    else $error("Data out driven with fuse off.");
  a_reset_follow: assert property ((!ext_reset_n) [*4] |-> chip_reset)
    else $error("Chip not held in reset.");
  a_page_hold: assert property (
      page_wr_valid && !page_wr_ready |=> page_wr_valid
      && $stable({page_wr_addr, page_wr_high, page_wr_byte}))
    else $error("Page write changed while stalled.");
  a_key_cleared: assert property ($fell(srst) |-> !prog_mode)
    else $error("Unlocked after reset.");
  c_unlock: cover property ($rose(prog_mode));
  c_exec: cover property (mem_exec_clk);
  c_page_take: cover property (page_wr_valid && page_wr_ready);
endmodule // jtag_prog_sva
bind jtag_prog_port jtag_prog_sva jtag_prog_sva_i (.clk, .srst, .tdo_oe, .test_port_enable_fuse,
  .ext_reset_n, .disable_set, .test_port_disable_bit, .chip_reset, .mem_cmd_strobe,
  .mem_exec_clk, .prog_mode, .page_wr_valid, .page_wr_ready, .page_wr_addr, .page_wr_high,
  .page_wr_byte);

// *** bench/jtag_host.sv ***
`timescale 1ns/10ps
module jtag_host (
  // Clock
  input wire clk,
  // Test pins
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo
);
  reg seen;
  reg [15:0] q;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // four pins only
  // One test clock period; the clock rests low between steps.
  task step(input reg m, input reg d);
    begin
      tms = m;
      tdi = d;
      repeat (8) @(negedge clk);
      seen = tdo;
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
    end
  endtask
  task scan(input reg ir, input reg [15:0] v, input integer n);
    integer i;
    begin
      step(1'b1, 1'b0);
      if (ir)
        step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      q = 16'h0000;
      for (i = 0; i < n; i = i + 1)
      begin
        step(i == n - 1, v[i]);
        q[i] = seen;
      end
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
endmodule // jtag_host

// *** bench/tb_jtag_prog_port.sv ***
`timescale 1ns/10ps
`include "jtag_prog_consts.vh"
module tb_jtag_prog_port;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg test_port_enable_fuse = 1'b1;
  reg ext_reset_n = 1'b1;
  reg disable_set = 1'b0;
  reg [15:0] reset_timeout_cycles = 16'h0100;
  reg [14:0] mem_result = 15'h5A3C;
  reg page_wr_ready = 1'b0;
  reg [15:0] flash_word = 16'hBEEF;
  wire tck, tms, tdi, tdo, tdo_oe, test_port_disable_bit, chip_reset;
  wire mem_cmd_strobe, mem_exec_clk, page_wr_valid, page_wr_high, prog_mode;
  wire [14:0] mem_cmd;
  wire [12:0] page_addr, page_wr_addr;
  wire [7:0] page_wr_byte;
  integer failures = 0, checks = 0, strobes = 0, execs = 0, i, k;
  reg [12:0] a0, e;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    strobes <= strobes + mem_cmd_strobe;
    execs <= execs + mem_exec_clk;
  end
  jtag_host jtag_host_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jtag_prog_port jtag_prog_port_i (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .test_port_enable_fuse(test_port_enable_fuse),
    .ext_reset_n(ext_reset_n), .disable_set(disable_set),
    .test_port_disable_bit(test_port_disable_bit), .chip_reset(chip_reset),
    .reset_timeout_cycles(reset_timeout_cycles), .mem_cmd(mem_cmd),
    .mem_cmd_strobe(mem_cmd_strobe), .mem_exec_clk(mem_exec_clk), .mem_result(mem_result),
    .page_addr(page_addr), .page_wr_valid(page_wr_valid), .page_wr_ready(page_wr_ready),
    .page_wr_addr(page_wr_addr), .page_wr_high(page_wr_high), .page_wr_byte(page_wr_byte),
    .flash_word(flash_word), .prog_mode(prog_mode));
  task check(input reg [31:0] seen, input reg [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wait_clk(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task ir(input reg [3:0] c);
    jtag_host_i.scan(1'b1, {12'h000, c}, 4);
  endtask
  task dr(input reg [15:0] v, input integer n);
    jtag_host_i.scan(1'b0, v, n);
  endtask
  // The scans take about 11,400 clocks; the limit allows three and a half times that.
  initial
  begin
    #400000;
    failures = failures + 1;
    complete_run;
  end
  initial
  begin
    wait_clk(6);
    srst = 1'b0;
    wait_clk(2);
    check(prog_mode, 1'b0);
    disable_set = 1'b1;
    wait_clk(1);
    disable_set = 1'b0;
    wait_clk(2);
    check(test_port_disable_bit, 1'b1);
    ext_reset_n = 1'b0;
    wait_clk(8);
    check(test_port_disable_bit, 1'b0);
    check(chip_reset, 1'b1);
    ext_reset_n = 1'b1;
    test_port_enable_fuse = 1'b0;
    wait_clk(300);
    test_port_enable_fuse = 1'b1;
    check(chip_reset, 1'b0);
    repeat (5) jtag_host_i.step(1'b1, 1'b0);
    jtag_host_i.step(1'b0, 1'b0);
    ir(`IR_COMMAND);
    dr(16'h1234, 15);
    check(strobes, 0);
    ir(`IR_HOLD_RESET);
    dr(16'h0001, 1);
    check(chip_reset, 1'b1);
    dr(16'h0000, 1);
    check(chip_reset, 1'b1);
    wait_clk(300);
    check(chip_reset, 1'b0);
    ir(`IR_UNLOCK);
    dr(16'hA371, 16);
    check(prog_mode, 1'b0);
    dr(16'hA370, 16);
    check(prog_mode, 1'b1);
    ir(`IR_COMMAND);
    dr(16'h2A55, 15);
    check(jtag_host_i.q, {1'b0, mem_result});
    check(mem_cmd, 15'h2A55);
    check(strobes, 1);
    jtag_host_i.step(1'b0, 1'b0);
    check(execs, 1);
    ir(`IR_PAGE_READ);
    a0 = page_addr;
    dr(16'h0000, 8);
    check(jtag_host_i.q, 16'h00EF);
    dr(16'h0000, 8);
    check(jtag_host_i.q, 16'h00BE);
    check(page_addr, a0 + 13'h0001);
    ir(`IR_PAGE_LOAD);
    a0 = page_addr;
    dr(16'h0000, 8);
    repeat (`PAGE_WRITE_TCK) jtag_host_i.step(1'b0, 1'b0);
    check(page_wr_valid, 1'b1);
    // Two loads beyond the FIFO depth are dropped while the memory stalls.
    for (i = 1; i < 34; i = i + 1)
      dr(i[15:0], 8);
    for (i = 0; i < 32; i = i + 1)
    begin
      k = 0;
      while (page_wr_valid !== 1'b1 && k < 20)
      begin
        wait_clk(1);
        k = k + 1;
      end
      e = a0 + i / 2;
      check({page_wr_addr, page_wr_high, page_wr_byte}, {e, i[0], i[7:0]});
      page_wr_ready = 1'b1;
      wait_clk(1);
      page_wr_ready = 1'b0;
    end
    wait_clk(5);
    check(page_wr_valid, 1'b0);
    ir(`IR_UNLOCK);
    dr(16'h0000, 16);
    check(prog_mode, 1'b0);
    complete_run;
  end
endmodule // tb_jtag_prog_port
